// file: shared/flash_ctl_pkg.sv
// Constants, encodings and carrier types of the serial flash control logic.
// Assumes a 100 MHz core clock and a serial clock that runs only while selected.
package flash_ctl_pkg;

	// ==========================================================================
	// Command codes and status layout
	// ==========================================================================
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] SECTOR_ERASE_CMD = 8'hd8;
	localparam logic [7:0] BULK_ERASE_CMD = 8'hc7;
	localparam logic [7:0] DEEP_SLEEP_CMD = 8'hb9;
	localparam logic [7:0] WAKE_SIGNATURE_CMD = 8'hab;
	localparam int BUSY_BIT = 0;
	localparam int WRITE_LATCH_BIT = 1;
	localparam int PROTECT_LO_BIT = 2;
	localparam int PROTECT_HI_BIT = 3;
	localparam int STATUS_LOCK_BIT = 7;
	localparam logic [1:0] PROTECT_RESET = 2'h0;
	localparam logic STATUS_LOCK_RESET = 1'b0;
	// Signature value is arbitrary.
	localparam logic [7:0] SIGNATURE_VALUE = 8'h5a;

	// ==========================================================================
	// Framing and array organisation
	// ==========================================================================
	localparam int ADDR_W = 18;
	localparam int PAGE_BYTES = 256;
	localparam logic [8:0] PAGE_FULL = 9'h100;
	localparam logic [8:0] BYTE_SAT = 9'h1ff;
	localparam logic [8:0] FIRST_DATA_BYTE = 9'h004;
	localparam logic [8:0] SIG_FIRST_BYTE = 9'h004;
	localparam logic [1:0] TOP_SECTOR = 2'h3;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_MHZ = 100;
	localparam int PUW_US = 10;
	localparam int STATUS_WRITE_US = 5000;
	localparam int PROGRAM_US = 1400;
	localparam int SECTOR_ERASE_MS = 1000;
	localparam int BULK_ERASE_MS = 3000;
	localparam int PUW_CYCLES = PUW_US * CLK_MHZ;
	localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_US * CLK_MHZ;
	localparam int PROGRAM_CYCLES = PROGRAM_US * CLK_MHZ;
	localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_MS * 1000 * CLK_MHZ;
	localparam int BULK_ERASE_CYCLES = BULK_ERASE_MS * 1000 * CLK_MHZ;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [2:0] {
		PWR_ACTIVE = 3'b001,
		PWR_STANDBY = 3'b010,
		PWR_DEEP = 3'b100
	} power_type;

	typedef enum logic [3:0] {
		CYC_IDLE = 4'b0001,
		CYC_STATUS = 4'b0010,
		CYC_PROGRAM = 4'b0100,
		CYC_ERASE = 4'b1000
	} cycle_type;

	typedef struct packed {
		logic wr;
		logic erase;
		logic erase_all;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} array_req_type;

endpackage

// file: logic/serial_flash_ctl.sv
// Control logic of a small serial flash: serial front end on the serial clock,
// power states, status bits, protection and internal cycles on the core clock.
// Assumes the array sits outside and takes array_req; a program only clears bits.

module serial_flash_ctl #(
	parameter int PUW_COUNT = flash_ctl_pkg::PUW_CYCLES,
	parameter int STATUS_WRITE_COUNT = flash_ctl_pkg::STATUS_WRITE_CYCLES,
	parameter int PROGRAM_COUNT = flash_ctl_pkg::PROGRAM_CYCLES,
	parameter int SECTOR_ERASE_COUNT = flash_ctl_pkg::SECTOR_ERASE_CYCLES,
	parameter int BULK_ERASE_COUNT = flash_ctl_pkg::BULK_ERASE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sck,
	input wire logic select_n,
	input wire logic serial_in,
	input wire logic pause_n,
	input wire logic write_protect_n,
	output logic serial_out,
	output logic serial_out_oe,
	output logic [7:0] flash_status,
	output flash_ctl_pkg::power_type power_state,
	output flash_ctl_pkg::array_req_type array_req
);

	// ==========================================================================
	// Link domain: pause detection
	// ==========================================================================
	// The pause follows the pause pin only while the serial clock is low, so an
	// edge of the pin during a high clock phase takes effect at the next low.
	logic pause_ff;
	logic paused;
	assign paused = sck ? pause_ff : ~pause_n;

	// The level held through a high phase is the one seen at the rising edge;
	// the rising-edge flops read the pin itself, since this flop changes there.
	always_ff @(posedge sck or posedge select_n) begin
		if (select_n) begin
			pause_ff <= 1'b0;
		end else begin
			pause_ff <= ~pause_n;
		end
	end

	// ==========================================================================
	// Link domain: shift in
	// ==========================================================================
	logic first_ff;
	logic frame_tgl_ff;
	logic [2:0] bit_cnt_ff;
	logic [8:0] byte_cnt_ff;
	logic [8:0] page_cnt_ff;
	logic [6:0] in_sr_ff;
	logic [7:0] opcode_ff;
	logic [23:0] addr_ff;
	logic [7:0] status_data_ff;
	logic [7:0] page_mem [flash_ctl_pkg::PAGE_BYTES];
	logic [1:0] busy_sync_ff;
	logic [1:0] deep_sync_ff;
	logic [7:0] status_s1_ff;
	logic [7:0] status_s2_ff;
	logic byte_done;
	logic [7:0] full_byte;
	logic store_page;

	assign byte_done = ~first_ff & (bit_cnt_ff == 3'h7);
	assign full_byte = {in_sr_ff, serial_in};
	assign store_page = byte_done & (opcode_ff == flash_ctl_pkg::PAGE_PROGRAM_CMD)
		& (byte_cnt_ff >= flash_ctl_pkg::FIRST_DATA_BYTE) & ~busy_sync_ff[1];

	// A new frame is marked by its first clock; deselect alone changes nothing
	// the core might still be reading.
	always_ff @(posedge sck or posedge select_n) begin
		if (select_n) begin
			first_ff <= 1'b1;
		end else if (pause_n) begin
			first_ff <= 1'b0;
		end
	end

	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			frame_tgl_ff <= 1'b0;
			bit_cnt_ff <= 3'h0;
			byte_cnt_ff <= 9'h000;
			page_cnt_ff <= 9'h000;
			in_sr_ff <= 7'h00;
			opcode_ff <= 8'h00;
			addr_ff <= 24'h000000;
			status_data_ff <= 8'h00;
		end else if (pause_n) begin
			in_sr_ff <= full_byte[6:0];
			if (first_ff) begin
				frame_tgl_ff <= ~frame_tgl_ff;
				bit_cnt_ff <= 3'h1;
				byte_cnt_ff <= 9'h000;
				page_cnt_ff <= 9'h000;
			end else begin
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				if (byte_done && byte_cnt_ff != flash_ctl_pkg::BYTE_SAT) begin
					byte_cnt_ff <= byte_cnt_ff + 9'h001;
				end
				if (store_page && page_cnt_ff != flash_ctl_pkg::PAGE_FULL) begin
					page_cnt_ff <= page_cnt_ff + 9'h001;
				end
			end
			if (byte_done) begin
				unique case (byte_cnt_ff)
					9'h000: opcode_ff <= full_byte;
					9'h001: begin
						addr_ff[23:16] <= full_byte;
						status_data_ff <= full_byte;
					end
					9'h002: addr_ff[15:8] <= full_byte;
					9'h003: addr_ff[7:0] <= full_byte;
					default: ;
				endcase
			end
		end
	end

	// Bytes past a full page all land on the start address, so only the last one sent wins there.
	always_ff @(posedge sck) begin
		if (pause_n && store_page) begin
			page_mem[page_cnt_ff[7:0] + addr_ff[7:0]] <= full_byte;
		end
	end

	// ==========================================================================
	// Link domain: status crossing and shift out
	// ==========================================================================
	// The status word only changes between cycles, and every loaded byte sits
	// behind at least two falling edges, so a per-bit double flop is enough.
	always_ff @(negedge sck or negedge rstn) begin
		if (!rstn) begin
			status_s1_ff <= 8'h00;
			status_s2_ff <= 8'h00;
		end else begin
			status_s1_ff <= flash_status;
			status_s2_ff <= status_s1_ff;
		end
	end

	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			busy_sync_ff <= 2'h0;
			deep_sync_ff <= 2'h0;
		end else begin
			busy_sync_ff <= {busy_sync_ff[0], flash_status[flash_ctl_pkg::BUSY_BIT]};
			deep_sync_ff <= {deep_sync_ff[0], power_state == flash_ctl_pkg::PWR_DEEP};
		end
	end

	logic [7:0] out_sr_ff;
	logic drive_ff;
	logic load_status;
	logic load_sig;

	assign load_status = (opcode_ff == flash_ctl_pkg::STATUS_READ_CMD) & ~deep_sync_ff[1];
	assign load_sig = (opcode_ff == flash_ctl_pkg::WAKE_SIGNATURE_CMD)
		& (byte_cnt_ff >= flash_ctl_pkg::SIG_FIRST_BYTE);

	always_ff @(negedge sck or posedge select_n) begin
		if (select_n) begin
			out_sr_ff <= 8'h00;
			drive_ff <= 1'b0;
		end else if (!paused) begin
			if (!first_ff && bit_cnt_ff == 3'h0 && byte_cnt_ff != 9'h000 && (load_status || load_sig)) begin
				out_sr_ff <= load_sig ? flash_ctl_pkg::SIGNATURE_VALUE : status_s2_ff;
				drive_ff <= 1'b1;
			end else begin
				out_sr_ff <= {out_sr_ff[6:0], 1'b0};
			end
		end
	end

	assign serial_out = out_sr_ff[7];
	assign serial_out_oe = drive_ff & ~paused & ~select_n;

	// ==========================================================================
	// Core domain: input synchronisers
	// ==========================================================================
	logic [2:0] sel_sync_ff;
	logic [1:0] wp_sync_ff;
	logic [1:0] tgl_sync_ff;
	logic tgl_seen_ff;
	logic frame_end;
	logic clocked;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sel_sync_ff <= 3'h7;
			wp_sync_ff <= 2'h3;
			tgl_sync_ff <= 2'h0;
			tgl_seen_ff <= 1'b0;
		end else begin
			sel_sync_ff <= {sel_sync_ff[1:0], select_n};
			wp_sync_ff <= {wp_sync_ff[0], write_protect_n};
			tgl_sync_ff <= {tgl_sync_ff[0], frame_tgl_ff};
			if (frame_end) begin
				tgl_seen_ff <= tgl_sync_ff[1];
			end
		end
	end

	// The link fields are quiet once select is high, so they are read directly.
	assign frame_end = sel_sync_ff[1] & ~sel_sync_ff[2];
	assign clocked = tgl_sync_ff[1] != tgl_seen_ff;

	// ==========================================================================
	// Core domain: command qualification
	// ==========================================================================
	logic wel_ff;
	logic [1:0] protect_ff;
	logic lock_ff;
	logic pu_ok_ff;
	logic [31:0] pu_cnt_ff;
	flash_ctl_pkg::cycle_type cycle_ff;
	flash_ctl_pkg::power_type power_ff;

	function automatic logic sector_guarded(input logic [1:0] level, input logic [1:0] sector);
		unique case (level)
			2'h0: sector_guarded = 1'b0;
			2'h1: sector_guarded = sector == flash_ctl_pkg::TOP_SECTOR;
			2'h2: sector_guarded = sector[1];
			default: sector_guarded = 1'b1;
		endcase
	endfunction

	logic busy;
	logic deep;
	logic whole_bytes;
	logic hard_protect_mode;
	logic may_modify;
	logic [1:0] target_sector;
	logic do_write_enable_cmd;
	logic do_write_disable_cmd;
	logic do_status_write;
	logic do_program;
	logic do_sector_erase;
	logic do_bulk_erase;
	logic do_sleep;
	logic do_wake;

	assign busy = cycle_ff != flash_ctl_pkg::CYC_IDLE;
	assign deep = power_ff == flash_ctl_pkg::PWR_DEEP;
	assign whole_bytes = clocked & (bit_cnt_ff == 3'h0) & (byte_cnt_ff != 9'h000);
	assign hard_protect_mode = lock_ff & ~wp_sync_ff[1];
	assign target_sector = addr_ff[17:16];
	assign may_modify = frame_end & whole_bytes & ~deep & ~busy & wel_ff & pu_ok_ff;
	assign do_write_enable_cmd = frame_end & whole_bytes & ~deep & ~busy & (opcode_ff == flash_ctl_pkg::WRITE_ENABLE_CMD);
	assign do_write_disable_cmd = frame_end & whole_bytes & ~deep & ~busy & (opcode_ff == flash_ctl_pkg::WRITE_DISABLE_CMD);
	assign do_status_write = may_modify & (opcode_ff == flash_ctl_pkg::STATUS_WRITE_CMD)
		& (byte_cnt_ff == 9'h002) & ~hard_protect_mode;
	assign do_program = may_modify & (opcode_ff == flash_ctl_pkg::PAGE_PROGRAM_CMD)
		& (byte_cnt_ff > flash_ctl_pkg::FIRST_DATA_BYTE - 9'h001) & (page_cnt_ff != 9'h000)
		& ~sector_guarded(protect_ff, target_sector);
	assign do_sector_erase = may_modify & (opcode_ff == flash_ctl_pkg::SECTOR_ERASE_CMD)
		& (byte_cnt_ff == 9'h004) & ~sector_guarded(protect_ff, target_sector);
	assign do_bulk_erase = may_modify & (opcode_ff == flash_ctl_pkg::BULK_ERASE_CMD)
		& (byte_cnt_ff == 9'h001) & (protect_ff == 2'h0);
	assign do_sleep = frame_end & whole_bytes & ~deep & ~busy
		& (opcode_ff == flash_ctl_pkg::DEEP_SLEEP_CMD) & (byte_cnt_ff == 9'h001);
	assign do_wake = frame_end & clocked & deep & (byte_cnt_ff != 9'h000)
		& (opcode_ff == flash_ctl_pkg::WAKE_SIGNATURE_CMD);

	// ==========================================================================
	// Core domain: power-up write delay
	// ==========================================================================
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pu_cnt_ff <= 32'h0;
			pu_ok_ff <= 1'b0;
		end else if (!pu_ok_ff) begin
			pu_cnt_ff <= pu_cnt_ff + 32'h1;
			pu_ok_ff <= pu_cnt_ff >= 32'(PUW_COUNT - 1);
		end
	end

	// ==========================================================================
	// Core domain: internal cycles
	// ==========================================================================
	logic [31:0] cyc_cnt_ff;
	logic [31:0] cyc_len_ff;
	logic [8:0] prog_idx_ff;
	logic [7:0] nv_data_ff;
	logic cycle_done;
	logic streaming;
	flash_ctl_pkg::array_req_type nxt_array_req;

	assign cycle_done = busy & (cyc_cnt_ff >= cyc_len_ff);
	assign streaming = (cycle_ff == flash_ctl_pkg::CYC_PROGRAM) & (prog_idx_ff < page_cnt_ff);

	always_comb begin
		nxt_array_req = '0;
		nxt_array_req.addr = addr_ff[flash_ctl_pkg::ADDR_W-1:0];
		if (streaming) begin
			// Page wrap keeps every byte inside the addressed page.
			nxt_array_req.wr = 1'b1;
			nxt_array_req.addr[7:0] = addr_ff[7:0] + prog_idx_ff[7:0];
			nxt_array_req.data = page_mem[addr_ff[7:0] + prog_idx_ff[7:0]];
		end else if (do_sector_erase || do_bulk_erase) begin
			nxt_array_req.erase = 1'b1;
			nxt_array_req.erase_all = do_bulk_erase;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			array_req <= '0;
		end else begin
			array_req <= nxt_array_req;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cycle_ff <= flash_ctl_pkg::CYC_IDLE;
			cyc_cnt_ff <= 32'h0;
			cyc_len_ff <= 32'h0;
			prog_idx_ff <= 9'h000;
			nv_data_ff <= 8'h00;
		end else begin
			unique case (cycle_ff)
				flash_ctl_pkg::CYC_IDLE: begin
					cyc_cnt_ff <= 32'h1;
					prog_idx_ff <= 9'h000;
					if (do_status_write) begin
						cycle_ff <= flash_ctl_pkg::CYC_STATUS;
						cyc_len_ff <= 32'(STATUS_WRITE_COUNT);
						nv_data_ff <= status_data_ff;
					end else if (do_program) begin
						cycle_ff <= flash_ctl_pkg::CYC_PROGRAM;
						cyc_len_ff <= 32'(PROGRAM_COUNT);
					end else if (do_sector_erase || do_bulk_erase) begin
						cycle_ff <= flash_ctl_pkg::CYC_ERASE;
						cyc_len_ff <= do_bulk_erase ? 32'(BULK_ERASE_COUNT) : 32'(SECTOR_ERASE_COUNT);
					end
				end
				flash_ctl_pkg::CYC_STATUS, flash_ctl_pkg::CYC_PROGRAM, flash_ctl_pkg::CYC_ERASE: begin
					// Pause does not touch a running cycle; a new frame's first clock clears page_cnt_ff and ends streaming.
					cyc_cnt_ff <= cyc_cnt_ff + 32'h1;
					if (streaming) begin
						prog_idx_ff <= prog_idx_ff + 9'h001;
					end
					if (cycle_done) begin
						cycle_ff <= flash_ctl_pkg::CYC_IDLE;
					end
				end
				default: cycle_ff <= flash_ctl_pkg::CYC_IDLE;
			endcase
		end
	end

	// ==========================================================================
	// Core domain: status bits
	// ==========================================================================
	// Protect level and lock are held in flops that reset to the delivery
	// state; true retention needs the cells outside this block.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wel_ff <= 1'b0;
			protect_ff <= flash_ctl_pkg::PROTECT_RESET;
			lock_ff <= flash_ctl_pkg::STATUS_LOCK_RESET;
		end else begin
			if (do_write_enable_cmd) begin
				wel_ff <= 1'b1;
			end else if (do_write_disable_cmd || cycle_done) begin
				wel_ff <= 1'b0;
			end
			if (cycle_done && cycle_ff == flash_ctl_pkg::CYC_STATUS) begin
				protect_ff <= {nv_data_ff[flash_ctl_pkg::PROTECT_HI_BIT],
					nv_data_ff[flash_ctl_pkg::PROTECT_LO_BIT]};
				lock_ff <= nv_data_ff[flash_ctl_pkg::STATUS_LOCK_BIT];
			end
		end
	end

	always_comb begin
		flash_status = 8'h00;
		flash_status[flash_ctl_pkg::BUSY_BIT] = busy;
		flash_status[flash_ctl_pkg::WRITE_LATCH_BIT] = wel_ff;
		flash_status[flash_ctl_pkg::PROTECT_LO_BIT] = protect_ff[0];
		flash_status[flash_ctl_pkg::PROTECT_HI_BIT] = protect_ff[1];
		flash_status[flash_ctl_pkg::STATUS_LOCK_BIT] = lock_ff;
	end

	// ==========================================================================
	// Core domain: power state
	// ==========================================================================
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			power_ff <= flash_ctl_pkg::PWR_STANDBY;
		end else begin
			unique case (power_ff)
				flash_ctl_pkg::PWR_DEEP: begin
					if (do_wake) begin
						power_ff <= flash_ctl_pkg::PWR_ACTIVE;
					end
				end
				flash_ctl_pkg::PWR_ACTIVE, flash_ctl_pkg::PWR_STANDBY: begin
					if (do_sleep) begin
						power_ff <= flash_ctl_pkg::PWR_DEEP;
					end else if (!sel_sync_ff[1] || busy || do_status_write || do_program
						|| do_sector_erase || do_bulk_erase) begin
						power_ff <= flash_ctl_pkg::PWR_ACTIVE;
					end else begin
						power_ff <= flash_ctl_pkg::PWR_STANDBY;
					end
				end
				default: power_ff <= flash_ctl_pkg::PWR_STANDBY;
			endcase
		end
	end

	assign power_state = power_ff;

endmodule // serial_flash_ctl

// file: verification/serial_flash_ctl_monitor.sv
// Checker on the ports of the serial flash control logic.
// Assumes the core clock and rstn of the design; bound at the foot of this file.
module serial_flash_ctl_monitor (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sck,
	input wire logic select_n,
	input wire logic serial_in,
	input wire logic pause_n,
	input wire logic write_protect_n,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic [7:0] flash_status,
	input wire flash_ctl_pkg::power_type power_state,
	input wire flash_ctl_pkg::array_req_type array_req
);
	// ==========================================================================
	// Port relations
	// ==========================================================================
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	a_oe_selected: assert property (serial_out_oe |-> !select_n)
		else $error("output driven while deselected");
	a_select_active: assert property (!select_n [*6] ##0 power_state != flash_ctl_pkg::PWR_DEEP |->
		power_state == flash_ctl_pkg::PWR_ACTIVE)
		else $error("selected but not active");
	a_standby_idle: assert property ((select_n && !flash_status[0]) [*6] |->
		power_state != flash_ctl_pkg::PWR_ACTIVE)
		else $error("idle and deselected but still active");
	a_busy_active: assert property (flash_status[0] |-> power_state == flash_ctl_pkg::PWR_ACTIVE)
		else $error("busy outside active state");
	a_req_busy: assert property ((array_req.wr || array_req.erase) |-> flash_status[0])
		else $error("array request without busy");
	a_latch_after_busy: assert property ($fell(flash_status[0]) |-> ##[0:2] !flash_status[1])
		else $error("write latch kept after cycle");
	a_protect_changes: assert property (!$stable(flash_status[3:2]) |->
		flash_status[0] || $past(flash_status[0]))
		else $error("protect level changed outside a cycle");
	a_hard_frozen: assert property ((!write_protect_n && flash_status[7] && !flash_status[0]) [*4] |=>
		$stable({flash_status[7], flash_status[3:2]}))
		else $error("status changed in hard protect");
	a_deep_holds: assert property (power_state == flash_ctl_pkg::PWR_DEEP && !select_n |=>
		power_state == flash_ctl_pkg::PWR_DEEP)
		else $error("left deep power-down while selected");
endmodule // serial_flash_ctl_monitor

bind serial_flash_ctl serial_flash_ctl_monitor serial_flash_ctl_monitor_i (.core_clk(core_clk), .rstn(rstn),
	.sck(sck), .select_n(select_n), .serial_in(serial_in), .pause_n(pause_n), .write_protect_n(write_protect_n),
	.serial_out(serial_out), .serial_out_oe(serial_out_oe), .flash_status(flash_status),
	.power_state(power_state), .array_req(array_req));

// file: verification/spi_host_model.sv
// Host model: drives select, serial clock (30 ns, idle low), data and pause.
// Assumes the device samples on rising and shifts out on falling serial clock.
module spi_host_model (
	output logic sck,
	output logic select_n,
	output logic serial_in,
	output logic pause_n,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	output logic paused_oe_seen
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle levels go out one step after time zero, so the select edge resets the link flops.
	initial begin
		#1;
		sck = 1'b0;
		select_n = 1'b1;
		serial_in = 1'b0;
		pause_n = 1'b1;
		paused_oe_seen = 1'b0;
	end

	// ==========================================================================
	// Frame
	// ==========================================================================
	// Sends nbits MSB first; a pause is held before bit hold_at while the clock keeps toggling.
	task automatic xfer(input logic [39:0] data, input int nbits, input int hold_at, output logic [7:0] rx);
		select_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			serial_in = data[nbits-1-i];
			if (i == hold_at) begin
				#7 pause_n = 1'b0;
				for (int k = 0; k < 4; k++) begin
					#8 sck = ~sck;
					#7 serial_in = ~serial_in;
					paused_oe_seen = paused_oe_seen | serial_out_oe;
				end
				#8 pause_n = 1'b1;
			end
			#15 sck = 1'b1;
			rx = {rx[6:0], serial_out};
			#15 sck = 1'b0;
		end
		#15 select_n = 1'b1;
		// A released data line must not keep showing its last bit.
		serial_in = ~serial_in;
		#60;
	endtask
endmodule // spi_host_model

// file: verification/testbench.sv
// Self-checking bench of the serial flash control logic with shortened cycle counts.
// Assumes the host model drives the link and the checker is bound to the design.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic write_protect_n = 1'b1;
	logic sck, select_n, serial_in, pause_n, serial_out, serial_out_oe, paused_oe_seen;
	logic [7:0] flash_status;
	logic [7:0] rx;
	flash_ctl_pkg::power_type power_state;
	flash_ctl_pkg::array_req_type array_req;
	flash_ctl_pkg::array_req_type last_req = '0;
	flash_ctl_pkg::array_req_type last_erase = '0;
	int miscompares = 0;
	int compares = 0;

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (array_req.wr === 1'b1) last_req <= array_req;
	always @(posedge core_clk) if (array_req.erase === 1'b1) last_erase <= array_req;

	serial_flash_ctl #(.PUW_COUNT(20), .STATUS_WRITE_COUNT(50), .PROGRAM_COUNT(300), .SECTOR_ERASE_COUNT(40),
		.BULK_ERASE_COUNT(60)) serial_flash_ctl_i (.core_clk(core_clk), .rstn(rstn), .sck(sck),
		.select_n(select_n), .serial_in(serial_in), .pause_n(pause_n), .write_protect_n(write_protect_n),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .flash_status(flash_status),
		.power_state(power_state), .array_req(array_req));
	spi_host_model spi_host_model_i (.sck(sck), .select_n(select_n), .serial_in(serial_in), .pause_n(pause_n),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .paused_oe_seen(paused_oe_seen));

	// ==========================================================================
	// Helpers
	// ==========================================================================
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cmd(input logic [39:0] data, input int nbits);
		spi_host_model_i.xfer(data, nbits, -1, rx);
		repeat (6) @(posedge core_clk);
		#1;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (flash_status[0] !== 1'b0 && n < 400) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (flash_status[0] !== 1'b0) begin
			miscompares++;
			complete_run();
		end
	endtask

	task automatic set_level(input logic [7:0] value);
		cmd(flash_ctl_pkg::WRITE_ENABLE_CMD, 8);
		cmd({flash_ctl_pkg::STATUS_WRITE_CMD, value}, 16);
		wait_idle();
	endtask

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic s_latch();
		check("reset status", 8'h00, flash_status);
		check("reset power", {5'h0, flash_ctl_pkg::PWR_STANDBY}, {5'h0, power_state});
		cmd(flash_ctl_pkg::WRITE_ENABLE_CMD, 8);
		check("latch set", 8'h02, flash_status);
		spi_host_model_i.xfer({flash_ctl_pkg::STATUS_READ_CMD, 8'h00}, 16, 11, rx);
		check("status read", 8'h02, rx);
		check("oe in pause", 8'h00, {7'h0, paused_oe_seen});
		cmd(flash_ctl_pkg::WRITE_DISABLE_CMD, 8);
		check("latch clear", 8'h00, flash_status);
	endtask

	task automatic s_count();
		cmd(flash_ctl_pkg::WRITE_ENABLE_CMD, 8);
		cmd({flash_ctl_pkg::SECTOR_ERASE_CMD, 23'h0}, 31);
		check("short frame", 8'h02, flash_status);
		cmd({flash_ctl_pkg::SECTOR_ERASE_CMD, 24'h0}, 32);
		check("erase busy", 8'h03, flash_status);
		check("busy power", {5'h0, flash_ctl_pkg::PWR_ACTIVE}, {5'h0, power_state});
		wait_idle();
		repeat (6) @(posedge core_clk);
		check("erase done", 8'h00, flash_status);
		check("standby", {5'h0, flash_ctl_pkg::PWR_STANDBY}, {5'h0, power_state});
	endtask

	task automatic s_protect();
		logic [2:0] free;
		logic ok;
		for (int lv = 0; lv < 4; lv++) begin
			free = (lv == 0) ? 3'h4 : 3'h4 - (3'h1 << (lv - 1));
			set_level({4'h0, lv[1:0], 2'h0});
			for (int s = 0; s < 5; s++) begin
				ok = (s == 4) ? (lv == 0) : (s < free);
				cmd(flash_ctl_pkg::WRITE_ENABLE_CMD, 8);
				if (s == 4)
					cmd(flash_ctl_pkg::BULK_ERASE_CMD, 8);
				else
					cmd({flash_ctl_pkg::SECTOR_ERASE_CMD, 6'h0, s[1:0], 16'h0}, 32);
				check("erase guard", {4'h0, lv[1:0], 1'b1, ok}, flash_status);
				if (ok && s < 4) check("erase sector", {6'h0, s[1:0]}, {6'h0, last_erase.addr[17:16]});
				if (ok) check("bulk flag", {7'h0, s == 4}, {7'h0, last_erase.erase_all});
				wait_idle();
			end
		end
	endtask

	task automatic s_hard();
		set_level(8'h8c);
		check("lock set", 8'h8c, flash_status);
		write_protect_n = 1'b0;
		set_level(8'h00);
		check("hard refuse", 8'h8e, flash_status);
		write_protect_n = 1'b1;
		set_level(8'h00);
		check("hard off", 8'h00, flash_status);
	endtask

	task automatic s_program();
		cmd(flash_ctl_pkg::WRITE_ENABLE_CMD, 8);
		cmd({flash_ctl_pkg::PAGE_PROGRAM_CMD, 24'h020107, 8'h3c}, 40);
		wait_idle();
		check("program page", 8'h01, last_req.addr[15:8]);
		check("program byte", 8'h07, last_req.addr[7:0]);
		check("program data", 8'h3c, last_req.data);
		check("program done", 8'h00, flash_status);
	endtask

	task automatic s_deep();
		cmd(flash_ctl_pkg::DEEP_SLEEP_CMD, 8);
		check("deep", {5'h0, flash_ctl_pkg::PWR_DEEP}, {5'h0, power_state});
		cmd(flash_ctl_pkg::WRITE_ENABLE_CMD, 8);
		check("deep ignores", 8'h00, flash_status);
		cmd({flash_ctl_pkg::WAKE_SIGNATURE_CMD, 32'h0}, 40);
		check("signature", flash_ctl_pkg::SIGNATURE_VALUE, rx);
		check("woken", {5'h0, flash_ctl_pkg::PWR_STANDBY}, {5'h0, power_state});
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		#1 rstn = 1'b1;
		repeat (30) @(posedge core_clk);
		s_latch();
		s_count();
		s_protect();
		s_hard();
		s_program();
		s_deep();
		complete_run();
	end
endmodule // testbench
